// ==== logic/gpt_bus_if.sv ====
// Interface joining the processor-side register master and the timer
`timescale 1ns/1ps
`default_nettype none
interface gpt_bus_if;
  logic peripheral_select_n;
  logic wr;
  logic [gpt_pkg::ADDR_W-1:0] addr;
  logic [gpt_pkg::DATA_W-1:0] wdata;
  logic [gpt_pkg::DATA_W-1:0] rdata;
  modport device (input peripheral_select_n, wr, addr, wdata, output rdata);
  modport host (output peripheral_select_n, wr, addr, wdata, input rdata);
endinterface
`default_nettype wire

// ==== logic/gpt_host.sv ====
// Processor-side end: turns user requests into timer register cycles
`timescale 1ns/1ps
`default_nettype none
module gpt_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User request
  input wire logic req,
  input wire logic req_wr,
  input wire logic [7:0] req_idx,
  input wire logic [31:0] req_wdata,
  // User answer
  output logic busy,
  output logic done,
  output logic [31:0] rsp_rdata,
  // Register bus
  gpt_bus_if.host bus
);
  typedef struct packed {
    gpt_pkg::gpt_hstate_t st;
    logic sel_n;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic done;
    logic busy;
    logic [31:0] rdata;
  } gpt_host_t;

  gpt_host_t s_r;
  gpt_host_t s_nxt;
  logic [31:0] clean;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    clean = req_wdata;
    clean[31:16] = gpt_pkg::ZERO16;
    if (req_idx == gpt_pkg::IDX_PRESCALER) begin
      clean[gpt_pkg::PRE_EXT_BIT] = 1'b0;
      clean[gpt_pkg::PRE_TEST_BIT] = 1'b0;
    end
    if (req_idx == gpt_pkg::IDX_CONTROL) begin
      clean[gpt_pkg::CTL_TEST_BIT] = 1'b0;
      clean[gpt_pkg::CTL_CLK_LO] = 1'b0;
      if (clean[gpt_pkg::CTL_OCTL_LO +: 2] == 2'h3) begin
        clean[gpt_pkg::CTL_OCTL_LO +: 2] = gpt_pkg::OCTL_KEEP;
      end
    end
    unique case (s_r.st)
      gpt_pkg::HST_IDLE: begin
        if (req) begin
          s_nxt.sel_n = 1'b0;
          s_nxt.wr = req_wr;
          s_nxt.addr = req_idx;
          s_nxt.wdata = req_wr ? clean : 32'h0000_0000;
          s_nxt.busy = 1'b1;
          s_nxt.st = req_wr ? gpt_pkg::HST_WRITE : gpt_pkg::HST_READ;
        end
      end
      gpt_pkg::HST_WRITE: begin
        s_nxt.sel_n = 1'b1;
        s_nxt.wr = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st = gpt_pkg::HST_IDLE;
      end
      gpt_pkg::HST_READ: begin
        // Device answer is registered; it stands only in the next cycle
        s_nxt.sel_n = 1'b1;
        s_nxt.st = gpt_pkg::HST_TAKE;
      end
      gpt_pkg::HST_TAKE: begin
        s_nxt.rdata = {16'h0000, bus.rdata[15:0]};
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st = gpt_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= gpt_pkg::HST_IDLE;
      s_r.sel_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.peripheral_select_n = s_r.sel_n;
  assign bus.wr = s_r.wr;
  assign bus.addr = s_r.addr;
  assign bus.wdata = s_r.wdata;
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign rsp_rdata = s_r.rdata;
endmodule
`default_nettype wire

// ==== logic/gpt_pkg.sv ====
// Package with register map, fields and reset values of the 16-bit timer
// How it works
// - Prescale value byte, resets to 01
// - Three-bit prescaler select field, resets 000
// - Internal clock only; host writes bit15 zero
// - Control bit 11 enables counting, resets 0
// - Clock source 0 internal, 2 prescaled
// - Output control: keep, set, clear
// - Control bit 6 inverts output polarity
// - Control read shows out and in levels
// - Mode bits 5:3, event bits 2:0
// - Reload register holds counter start value
// - Count register read-only, live counter
// - Upper sixteen bits reserved, host writes zero
// - Host writes zero to test bits
// - Decode word indexes 0c-0f under select low
package gpt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] IDX_PRESCALER = 8'h0c;
  localparam logic [7:0] IDX_CONTROL = 8'h0d;
  localparam logic [7:0] IDX_RELOAD = 8'h0e;
  localparam logic [7:0] IDX_COUNT = 8'h0f;
  localparam logic [7:0] PRESCALE_RST = 8'h01;
  localparam logic [2:0] SELECT_RST = 3'h0;
  localparam int PRE_EXT_BIT = 15;
  localparam int PRE_TEST_BIT = 14;
  localparam int PRE_SEL_LO = 8;
  localparam int CTL_OUT_BIT = 15;
  localparam int CTL_IN_BIT = 14;
  localparam int CTL_TEST_BIT = 12;
  localparam int CTL_EN_BIT = 11;
  localparam int CTL_CLK_LO = 9;
  localparam int CTL_OCTL_LO = 7;
  localparam int CTL_INV_BIT = 6;
  localparam int CTL_MODE_LO = 3;
  localparam int CTL_EVT_LO = 0;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_PRESCALED = 2'h2;
  localparam logic [1:0] OCTL_KEEP = 2'h0;
  localparam logic [1:0] OCTL_SET = 2'h1;
  localparam logic [1:0] OCTL_CLEAR = 2'h2;
  localparam logic [15:0] ZERO16 = 16'h0000;
  typedef enum logic [1:0] {HST_IDLE, HST_WRITE, HST_READ, HST_TAKE} gpt_hstate_t;
endpackage

// ==== logic/gpt_timer.sv ====
// Timer device end: registers, prescaler, counter and output pin
`timescale 1ns/1ps
`default_nettype none
module gpt_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  gpt_bus_if.device bus,
  // Timer pins
  input wire logic timer_in,
  output logic timer_out
);
  typedef struct packed {
    logic [7:0] prescale;
    logic [2:0] select;
    logic [7:0] pre_cnt;
    logic enable;
    logic [1:0] clk_src;
    logic [1:0] out_ctl;
    logic invert;
    logic [2:0] mode;
    logic [2:0] evt;
    logic [15:0] reload;
    logic [15:0] count;
    logic out_lvl;
    logic out_pin;
    logic in_s1;
    logic in_s2;
    logic [31:0] rdata;
  } gpt_dev_t;

  gpt_dev_t s_r;
  gpt_dev_t s_nxt;
  logic sel;
  logic pre_tick;
  logic tick;
  logic [15:0] ctl_rd;

  always_comb begin
    s_nxt = s_r;
    sel = ~bus.peripheral_select_n;
    // Second sync stage only; first stage feeds nothing else
    s_nxt.in_s1 = timer_in;
    s_nxt.in_s2 = s_r.in_s1;
    pre_tick = 1'b0;
    if (s_r.enable) begin
      if (s_r.pre_cnt >= s_r.prescale) begin
        s_nxt.pre_cnt = 8'h00;
        pre_tick = 1'b1;
      end else begin
        s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
      end
    end
    // Codes 1 and 3 are forbidden; treated as stopped clock
    tick = s_r.enable && ((s_r.clk_src == gpt_pkg::CLK_INTERNAL) ||
           (s_r.clk_src == gpt_pkg::CLK_PRESCALED && pre_tick));
    if (tick) begin
      if (s_r.count == gpt_pkg::ZERO16) begin
        s_nxt.count = s_r.reload;
        unique case (s_r.out_ctl)
          gpt_pkg::OCTL_SET: s_nxt.out_lvl = 1'b1;
          gpt_pkg::OCTL_CLEAR: s_nxt.out_lvl = 1'b0;
          default: s_nxt.out_lvl = s_r.out_lvl;
        endcase
      end else begin
        s_nxt.count = s_r.count - 16'h0001;
      end
    end
    s_nxt.out_pin = s_nxt.out_lvl ^ s_nxt.invert;
    ctl_rd = {s_r.out_pin, s_r.in_s2, 1'b0, 1'b0, s_r.enable, s_r.clk_src,
              s_r.out_ctl, s_r.invert, s_r.mode, s_r.evt};
    s_nxt.rdata = 32'h0000_0000;
    if (sel && !bus.wr) begin
      unique case (bus.addr)
        gpt_pkg::IDX_PRESCALER: s_nxt.rdata = {16'h0000, 5'h00, s_r.select, s_r.prescale};
        gpt_pkg::IDX_CONTROL: s_nxt.rdata = {16'h0000, ctl_rd};
        gpt_pkg::IDX_RELOAD: s_nxt.rdata = {16'h0000, s_r.reload};
        gpt_pkg::IDX_COUNT: s_nxt.rdata = {16'h0000, s_r.count};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (sel && bus.wr) begin
      unique case (bus.addr)
        gpt_pkg::IDX_PRESCALER: begin
          s_nxt.prescale = bus.wdata[7:0];
          s_nxt.select = bus.wdata[gpt_pkg::PRE_SEL_LO +: 3];
        end
        gpt_pkg::IDX_CONTROL: begin
          s_nxt.enable = bus.wdata[gpt_pkg::CTL_EN_BIT];
          s_nxt.clk_src = bus.wdata[gpt_pkg::CTL_CLK_LO +: 2];
          s_nxt.out_ctl = bus.wdata[gpt_pkg::CTL_OCTL_LO +: 2];
          s_nxt.invert = bus.wdata[gpt_pkg::CTL_INV_BIT];
          s_nxt.mode = bus.wdata[gpt_pkg::CTL_MODE_LO +: 3];
          s_nxt.evt = bus.wdata[gpt_pkg::CTL_EVT_LO +: 3];
          s_nxt.out_pin = s_nxt.out_lvl ^ s_nxt.invert;
        end
        gpt_pkg::IDX_RELOAD: s_nxt.reload = bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.prescale <= gpt_pkg::PRESCALE_RST;
      s_r.select <= gpt_pkg::SELECT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdata = s_r.rdata;
  assign timer_out = s_r.out_pin;
endmodule
`default_nettype wire

// ==== testbench/general_purpose_16bit_timer_test.sv ====
// Bench driving the host end against the timer end
`timescale 1ns/1ps
`default_nettype none
module general_purpose_16bit_timer_test;
  logic clk, rstn, req, req_wr, busy, done, timer_in, timer_out;
  logic [7:0] req_idx;
  logic [31:0] req_wdata, rsp_rdata, rd;
  int errors = 0, compares = 0, cyc = 0, t0 = 0, dt;
  logic [31:0] d;
  gpt_bus_if bus ();
  gpt_timer gpt_timer_i (.clk(clk), .rstn(rstn), .bus(bus), .timer_in(timer_in), .timer_out(timer_out));
  gpt_host gpt_host_i (.clk(clk), .rstn(rstn), .req(req), .req_wr(req_wr), .req_idx(req_idx),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rsp_rdata(rsp_rdata), .bus(bus));
  gpt_chk gpt_chk_i (.clk(clk), .rstn(rstn), .peripheral_select_n(bus.peripheral_select_n), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] v);
    int n;
    @(posedge clk) #1;
    req = 1'h1;
    req_wr = w;
    req_idx = idx;
    req_wdata = v;
    @(posedge clk) #1;
    req = 1'h0;
    check({31'h0, busy}, 32'h1);
    for (n = 0; n < 20 && done !== 1'h1; n++) @(posedge clk) #1;
    check({31'h0, done}, 32'h1);
    check({31'h0, busy}, 32'h0);
    t0 = cyc;
    rd = rsp_rdata;
  endtask
  // Two count reads some cycles apart; distance in counts and cycles
  task automatic span;
    logic [15:0] c1;
    int t1;
    xfer(1'h0, 8'h0f, 32'h0);
    c1 = rd[15:0];
    t1 = t0;
    repeat (40) @(posedge clk);
    xfer(1'h0, 8'h0f, 32'h0);
    d = {16'h0000, c1 - rd[15:0]};
    dt = t0 - t1;
  endtask
  task automatic t_reset;
    xfer(1'h0, 8'h0c, 32'h0);
    check(rd, 32'h1);
    xfer(1'h0, 8'h0d, 32'h0);
    check(rd, 32'h0);
    xfer(1'h0, 8'h0e, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_regs;
    xfer(1'h1, 8'h0c, 32'hffffc7ff);
    xfer(1'h0, 8'h0c, 32'h0);
    check(rd & 32'hffff87ff, 32'h7ff);
    xfer(1'h1, 8'h0e, 32'h1234abcd);
    xfer(1'h0, 8'h0e, 32'h0);
    check(rd, 32'habcd);
    xfer(1'h1, 8'h0f, 32'h5555);
    xfer(1'h0, 8'h0f, 32'h0);
    check(rd, 32'h0);
    xfer(1'h0, 8'h10, 32'h0);
    check(rd, 32'h0);
    xfer(1'h1, 8'h0d, 32'h13ff);
    xfer(1'h0, 8'h0d, 32'h0);
    check(rd & 32'hffffdfff, 32'h807f);
    check({31'h0, timer_out}, 32'h1);
  endtask
  task automatic t_run;
    xfer(1'h1, 8'h0e, 32'h5);
    xfer(1'h1, 8'h0d, 32'h880);
    repeat (14) @(posedge clk);
    #1;
    check({31'h0, timer_out}, 32'h1);
    xfer(1'h1, 8'h0d, 32'h900);
    repeat (14) @(posedge clk);
    #1;
    check({31'h0, timer_out}, 32'h0);
    xfer(1'h1, 8'h0e, 32'hffff);
    span();
    check(d, dt);
    xfer(1'h1, 8'h0d, 32'h0);
    span();
    check(d, 32'h0);
    xfer(1'h1, 8'h0c, 32'h3);
    xfer(1'h1, 8'h0d, 32'hc00);
    span();
    check({31'h0, d * 4 + 4 >= dt && d * 4 <= dt + 4}, 32'h1);
    timer_in = 1'h1;
    xfer(1'h0, 8'h0d, 32'h0);
    check({31'h0, rd[14]}, 32'h1);
  endtask
  task automatic test_done;
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    test_done();
  end
  initial begin
    {rstn, req, req_wr, timer_in, req_idx, req_wdata} = '0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'h1;
    t_reset();
    t_regs();
    t_run();
    test_done();
  end
endmodule
`default_nettype wire

// ==== testbench/gpt_chk.sv ====
// Checker on the bus between host end and timer end
`timescale 1ns/1ps
`default_nettype none
module gpt_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic peripheral_select_n,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata
);
  logic [10:0] pre_r;
  logic [11:0] ctl_r;
  logic [15:0] rel_r;
  logic rd;
  logic wt;
  assign rd = !peripheral_select_n && !wr;
  assign wt = !peripheral_select_n && wr;
  // Shadow of the last write, so read-back can be judged
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_r <= 11'h001;
      ctl_r <= 12'h000;
      rel_r <= 16'h0000;
    end else if (wt) begin
      if (addr == 8'h0c) pre_r <= wdata[10:0];
      if (addr == 8'h0d) ctl_r <= wdata[11:0];
      if (addr == 8'h0e) rel_r <= wdata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_idle; (peripheral_select_n || wr) |=> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_resv; rd |=> rdata[31:16] == 16'h0; endproperty
  a_resv: assert property (p_resv) else $error("upper half not zero");
  property p_pre; rd && addr == 8'h0c |=> rdata[10:0] == pre_r && !rdata[15]; endproperty
  a_pre: assert property (p_pre) else $error("prescaler read-back wrong");
  property p_ctl; rd && addr == 8'h0d |=> rdata[11:0] == ctl_r; endproperty
  a_ctl: assert property (p_ctl) else $error("control read-back wrong");
  property p_rel; rd && addr == 8'h0e |=> rdata[15:0] == rel_r; endproperty
  a_rel: assert property (p_rel) else $error("reload read-back wrong");
  property p_unmap; rd && (addr < 8'h0c || addr > 8'h0f) |=> rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_sel; !peripheral_select_n |=> peripheral_select_n; endproperty
  a_sel: assert property (p_sel) else $error("select longer than one cycle");
  property p_wsan; wt |-> wdata[31:16] == 16'h0
    && !(addr == 8'h0d && (wdata[12] || wdata[9] || wdata[8:7] == 2'h3))
    && !(addr == 8'h0c && wdata[15]); endproperty
  a_wsan: assert property (p_wsan) else $error("write carries forbidden bits");
endmodule
`default_nettype wire
